// File: hw/adc_ctrl_pkg.sv
/*
  Shared constants for the converter control block: register pointer
  codes, configuration field positions, reset values and timing counts.
  Assumes a 100 MHz system clock.
*/
package adc_ctrl_pkg;

  // ********************************************************************
  // Register pointer codes
  // ********************************************************************
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CHAN   = 8'h01;
  localparam logic [7:0] PTR_CFG    = 8'h02;

  // ********************************************************************
  // Field layout and reset values
  // ********************************************************************
  localparam int          CFG_CMD_BIT  = 8;
  localparam int          CFG_AUTO_BIT = 12;
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  localparam logic [7:0]  CHAN_RESET   = 8'h01;
  localparam int          CH_N         = 8;
  localparam int          CH_W         = 3;
  localparam int          CODE_W       = 12;
  localparam logic        ALERT_CLEAR  = 1'b0;
  localparam logic [6:0]  SLAVE_ADDR_DEFAULT = 7'h2F;

  // ********************************************************************
  // Bus framing and write byte slots
  // ********************************************************************
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [1:0] WSEL_PTR = 2'h0;
  localparam logic [1:0] WSEL_HI  = 2'h1;
  localparam logic [1:0] WSEL_LO  = 2'h2;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS  = 550;
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: hw/conv_timer.sv
/*
  Conversion timer: holds the track-and-hold for one conversion time
  after a start pulse and then pulses done.
  Assumes start is a one-cycle pulse on the system clock.
*/
`timescale 1ns/100ps
module conv_timer
#(
  parameter int CYCLES = adc_ctrl_pkg::CONV_CYCLES
)
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_b,
  // Control.
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import adc_ctrl_pkg::*;

  localparam int          CW       = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);
  localparam int          CONV_LEN = CYCLES;

  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic          done_ff;

  // Counts the hold time; the sample is held while busy is high.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (start && !busy_ff)
      begin
        busy_ff <= 1'b1;
        cnt_ff  <= '0;
      end
      else if (busy_ff)
      begin
        if (cnt_ff == CNT_LAST)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
        begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

  a_hold_length: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(busy_ff) |-> ##[CONV_LEN:CONV_LEN] !busy_ff)
    else $error("hold time is not one conversion time");

endmodule // conv_timer

// File: hw/adc_conversion_mode_control.sv
/*
  Serial-side converter control: a two-wire slave port with a persistent
  register pointer, and the sample and command conversion modes with a
  channel sequencer.
  Assumes scl is the bus master's clock and stands still outside frames,
  and that the analog core delivers adc_code when a conversion ends.
*/
// How it works
// - Reads return two-byte lots while master acknowledges
// - Pointer persists across reads and transactions
// - Master NACK makes device release the data line
// - Read starts with address, read bit, device ACK
// - Each start pin pulse gives one conversion
// - Reset gives sample mode on channel 0
// - Mode bits equal select sample mode
// - Command bit set, autocycle clear selects command mode
// - Start pulses step channels upward from lowest
// - Falling start edge holds sample for conversion
// - Command mode: result read starts next conversion
// - Conversion starts first clock rise after ACK
// - First three result bits name the channel
// - Command mode powers converter down after conversion
// - Sequence wraps to lowest enabled channel forever
// - NACK stops conversions, configuration kept
// - Resume continues after last channel read
// - Channel rewrite restarts from first selected channel
// - Channel register is a per-channel enable mask
// - Pointer codes: result, channel, configuration
// - Byte one: channel, alert, top bits; two: rest
`timescale 1ns/100ps
module adc_conversion_mode_control
#(
  parameter logic [6:0] SLAVE_ADDR  = adc_ctrl_pkg::SLAVE_ADDR_DEFAULT,
  parameter int         CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES
)
(
  // System clock and reset.
  input  wire logic                            clock,
  input  wire logic                            rst_b,
  // Two-wire serial link.
  input  wire logic                            scl,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe,
  // Conversion start pin, active low.
  input  wire logic                            conversion_start_pin_b,
  // Analog core.
  input  wire logic [adc_ctrl_pkg::CODE_W-1:0] adc_code,
  output logic                                 adc_hold,
  output logic                                 adc_power_on,
  output logic [adc_ctrl_pkg::CH_W-1:0]        adc_channel
);
  import adc_ctrl_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_ADDR  = 5'b0_0010,
    ST_WRITE = 5'b0_0100,
    ST_READ  = 5'b0_1000,
    ST_SPARE = 5'b1_0000
  } link_state_e;

  // ********************************************************************
  // Link domain (scl)
  // ********************************************************************
  link_state_e      state_ff;
  logic             start_tgl_ff;
  logic             start_seen_ff;
  logic [3:0]       bitcnt_ff;
  logic [6:0]       shift_ff;
  logic             rw_ff;
  logic             ack_ff;
  logic             rsel_ff;
  logic [1:0]       wsel_ff;
  logic [7:0]       hi_ff;
  logic [7:0]       ptr_ff;
  logic [CH_N-1:0]  chan_ff;
  logic [15:0]      cfg_ff;
  logic             chan_tgl_ff;
  logic             conv_tgl_ff;
  logic [CH_W-1:0]  tx_ch_ff;
  logic             sda_oe_ff;
  logic             new_start;
  logic [7:0]       byte_in;
  logic             cmd_mode;
  logic [CH_W-1:0]  ch_now;
  logic [15:0]      tx_word;
  logic             tx_bit;

  // System-domain signals read by the link side.
  logic [15:0]      result_ff;
  logic [CH_W-1:0]  next_ch_ff;

  // A start is a falling data line while the clock is high.
  always_ff @(negedge sda_in or negedge rst_b)
  begin
    if (!rst_b)
      start_tgl_ff <= 1'b0;
    else if (scl)
      start_tgl_ff <= ~start_tgl_ff;
  end

  assign new_start = start_tgl_ff ^ start_seen_ff;
  assign byte_in   = {shift_ff, sda_in};
  assign cmd_mode  = cfg_ff[CFG_CMD_BIT] & ~cfg_ff[CFG_AUTO_BIT];

  // Bit counter and input shifter; a start realigns the frame.
  always_ff @(posedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_seen_ff <= 1'b0;
      bitcnt_ff     <= 4'h0;
      shift_ff      <= 7'h00;
    end
    else
    begin
      start_seen_ff <= start_tgl_ff;
      shift_ff      <= byte_in[6:0];
      if (new_start)
        bitcnt_ff <= 4'h1;
      else if (bitcnt_ff == BIT_ACK)
        bitcnt_ff <= 4'h0;
      else
        bitcnt_ff <= bitcnt_ff + 4'h1;
    end
  end

  // Frame sequencing, registers and conversion requests.
  always_ff @(posedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff    <= ST_IDLE;
      rw_ff       <= 1'b0;
      ack_ff      <= 1'b0;
      rsel_ff     <= 1'b0;
      wsel_ff     <= WSEL_PTR;
      hi_ff       <= 8'h00;
      ptr_ff      <= PTR_RESULT;
      chan_ff     <= CHAN_RESET;
      cfg_ff      <= CFG_RESET;
      chan_tgl_ff <= 1'b0;
      conv_tgl_ff <= 1'b0;
    end
    else if (new_start)
    begin
      state_ff <= ST_ADDR;
      ack_ff   <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_ADDR:
        begin
          if (bitcnt_ff == BIT_LAST)
          begin
            if (byte_in[7:1] == SLAVE_ADDR)
            begin
              ack_ff <= 1'b1;
              rw_ff  <= byte_in[0];
            end
            else
              state_ff <= ST_IDLE;
          end
          else if (bitcnt_ff == BIT_ACK)
          begin
            ack_ff   <= 1'b0;
            state_ff <= rw_ff ? ST_READ : ST_WRITE;
            wsel_ff  <= WSEL_PTR;
            rsel_ff  <= 1'b0;
          end
        end
        ST_WRITE:
        begin
          if (bitcnt_ff == BIT_LAST)
          begin
            ack_ff <= 1'b1;
            case (wsel_ff)
              WSEL_PTR: ptr_ff <= byte_in;
              WSEL_HI:
              begin
                if (ptr_ff == PTR_CHAN)
                begin
                  chan_ff     <= byte_in;
                  chan_tgl_ff <= ~chan_tgl_ff;
                end
                else
                  hi_ff <= byte_in;
              end
              default:
              begin
                if (ptr_ff == PTR_CFG)
                  cfg_ff <= {hi_ff, byte_in};
              end
            endcase
          end
          else if (bitcnt_ff == BIT_ACK)
          begin
            ack_ff <= 1'b0;
            case (wsel_ff)
              WSEL_PTR: wsel_ff <= WSEL_HI;
              WSEL_HI:  wsel_ff <= (ptr_ff == PTR_CHAN) ? WSEL_PTR : WSEL_LO;
              default:  wsel_ff <= WSEL_PTR;
            endcase
          end
        end
        ST_READ:
        begin
          // The master's answer after each byte decides whether to go on.
          if (bitcnt_ff == BIT_ACK)
          begin
            if (sda_in)
              state_ff <= ST_IDLE;
            else
              rsel_ff <= ~rsel_ff;
          end
          else if (bitcnt_ff == 4'h0 && !rsel_ff && ptr_ff == PTR_RESULT && cmd_mode)
            conv_tgl_ff <= ~conv_tgl_ff;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Transmit word; the channel field is frozen at the first bit of a lot.
  // The system side only changes result_ff and next_ch_ff while a
  // conversion runs or after a channel write, which completes well inside one bit time, so the
  // bits read here are settled when the link samples them.
  always_comb
  begin
    ch_now = tx_ch_ff;
    if (bitcnt_ff == 4'h0 && !rsel_ff)
      ch_now = cmd_mode ? next_ch_ff : result_ff[15:13];
    case (ptr_ff)
      PTR_RESULT: tx_word = {ch_now, result_ff[12:0]};
      PTR_CHAN:   tx_word = {8'h00, chan_ff};
      PTR_CFG:    tx_word = cfg_ff;
      default:    tx_word = 16'h0000;
    endcase
    tx_bit = tx_word[{~rsel_ff, 3'h7 - bitcnt_ff[2:0]}];
  end

  // Drives the data line low on the falling clock edge.
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_oe_ff <= 1'b0;
      tx_ch_ff  <= '0;
    end
    else
    begin
      if (bitcnt_ff == 4'h0 && !rsel_ff)
        tx_ch_ff <= ch_now;
      if (ack_ff && bitcnt_ff == BIT_ACK)
        sda_oe_ff <= 1'b1;
      else if (state_ff == ST_READ && bitcnt_ff != BIT_ACK)
        sda_oe_ff <= ~tx_bit;
      else
        sda_oe_ff <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_ff;

  // ********************************************************************
  // System domain (clock)
  // ********************************************************************
  logic [2:0]      pin_sync_ff;
  logic [2:0]      conv_sync_ff;
  logic [2:0]      chan_sync_ff;
  logic [1:0]      cmd_sync_ff;
  logic [CH_N-1:0] mask_ff;
  logic [CH_W-1:0] last_ch_ff;
  logic            restart_ff;
  logic [CH_W-1:0] conv_ch_ff;
  logic            power_ff;
  logic            busy;
  logic            done;
  logic            sample_fall;
  logic            cmd_go;
  logic            chan_ev;
  logic            go;

  // Synchronisers for the pin and for events from the link side.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_sync_ff  <= 3'b111;
      conv_sync_ff <= 3'b000;
      chan_sync_ff <= 3'b000;
      cmd_sync_ff  <= 2'b00;
    end
    else
    begin
      pin_sync_ff  <= {pin_sync_ff[1:0], conversion_start_pin_b};
      conv_sync_ff <= {conv_sync_ff[1:0], conv_tgl_ff};
      chan_sync_ff <= {chan_sync_ff[1:0], chan_tgl_ff};
      cmd_sync_ff  <= {cmd_sync_ff[0], cmd_mode};
    end
  end

  assign sample_fall = pin_sync_ff[2] & ~pin_sync_ff[1] & ~cmd_sync_ff[1];
  assign cmd_go      = (conv_sync_ff[2] ^ conv_sync_ff[1]) & cmd_sync_ff[1];
  assign chan_ev     = chan_sync_ff[2] ^ chan_sync_ff[1];
  assign go          = (sample_fall | cmd_go) & ~busy;

  // Picks the lowest enabled channel above the last one, else wraps.
  function automatic logic [CH_W-1:0] pick_next(input logic [CH_N-1:0] mask,
                                                input logic [CH_W-1:0] last,
                                                input logic            restart);
    logic [CH_W-1:0] lo;
    logic [CH_W-1:0] up;
    logic            hit;
    lo  = '0;
    up  = '0;
    hit = 1'b0;
    for (int i = CH_N - 1; i >= 0; i--)
    begin
      if (mask[i])
        lo = CH_W'(i);
      if (mask[i] && CH_W'(i) > last)
      begin
        up  = CH_W'(i);
        hit = 1'b1;
      end
    end
    return (hit && !restart) ? up : lo;
  endfunction

  // Channel sequencer; a new mask wins over a launch in the same cycle.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_ff    <= CHAN_RESET;
      last_ch_ff <= '0;
      restart_ff <= 1'b1;
      next_ch_ff <= '0;
      conv_ch_ff <= '0;
    end
    else
    begin
      if (chan_ev)
      begin
        mask_ff    <= chan_ff;
        restart_ff <= 1'b1;
      end
      else if (go)
        restart_ff <= 1'b0;
      if (go)
      begin
        last_ch_ff <= next_ch_ff;
        conv_ch_ff <= next_ch_ff;
      end
      next_ch_ff <= pick_next(mask_ff, last_ch_ff, restart_ff);
    end
  end

  // Result capture and converter power.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_ff <= 16'h0000;
      power_ff  <= 1'b1;
    end
    else
    begin
      if (done)
        result_ff <= {conv_ch_ff, ALERT_CLEAR, adc_code};
      if (go)
        power_ff <= 1'b1;
      else if (done && cmd_sync_ff[1])
        power_ff <= 1'b0;
      else if (!cmd_sync_ff[1] && !busy)
        power_ff <= 1'b1;
    end
  end

  conv_timer #(
    .CYCLES (CONV_CYCLES)
  ) u_conv_timer (
    .clock (clock),
    .rst_b (rst_b),
    .start (go),
    .busy  (busy),
    .done  (done)
  );

  assign adc_hold     = busy;
  assign adc_power_on = power_ff;
  assign adc_channel  = conv_ch_ff;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_sample_launch: assert property (@(posedge clock) disable iff (!rst_b)
    (sample_fall && !busy) |=> (busy && adc_channel == $past(next_ch_ff)))
    else $error("start pin edge did not launch one conversion");
  a_cmd_launch: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_go && !busy) |=> busy)
    else $error("result read did not launch a conversion");
  a_power_down: assert property (@(posedge clock) disable iff (!rst_b)
    (done && cmd_sync_ff[1] && !go) |=> !adc_power_on)
    else $error("converter stayed powered after command conversion");
  a_mask_restart: assert property (@(posedge clock) disable iff (!rst_b)
    chan_ev |=> (restart_ff && mask_ff == $past(chan_ff)))
    else $error("channel rewrite did not restart the sequence");
  a_enabled_channel: assert property (@(posedge clock) disable iff (!rst_b)
    (go && mask_ff != '0 && !chan_ev && $stable(mask_ff) && $stable(last_ch_ff)
      && $stable(restart_ff)) |-> mask_ff[next_ch_ff])
    else $error("launched channel is not enabled");
  a_nack_release: assert property (@(posedge scl) disable iff (!rst_b)
    (state_ff == ST_READ && bitcnt_ff == BIT_ACK && sda_in && !new_start)
      |=> (!sda_oe_ff && state_ff == ST_IDLE))
    else $error("data line still driven after master not-acknowledge");
  a_ptr_keeps: assert property (@(posedge scl) disable iff (!rst_b)
    (state_ff != ST_WRITE) |=> $stable(ptr_ff))
    else $error("pointer changed outside a write");
  a_addr_ack: assert property (@(posedge scl) disable iff (!rst_b)
    (state_ff == ST_ADDR && bitcnt_ff == BIT_LAST && byte_in[7:1] == SLAVE_ADDR
      && !new_start) |=> ack_ff)
    else $error("own address not acknowledged");
  a_conv_on_lot: assert property (@(posedge scl) disable iff (!rst_b)
    (state_ff == ST_READ && bitcnt_ff == 4'h0 && !rsel_ff && ptr_ff == PTR_RESULT
      && cmd_mode && !new_start) |=> (conv_tgl_ff != $past(conv_tgl_ff)))
    else $error("lot start in command mode did not request a conversion");

  c_sample_conv: cover property (@(posedge clock) disable iff (!rst_b) sample_fall && !busy);
  c_cmd_conv: cover property (@(posedge clock) disable iff (!rst_b) cmd_go && !busy);
  c_chan_write: cover property (@(posedge clock) disable iff (!rst_b) chan_ev);
  c_nack: cover property (@(posedge scl) disable iff (!rst_b)
    state_ff == ST_READ && bitcnt_ff == BIT_ACK && sda_in);

endmodule // adc_conversion_mode_control

// File: verification/i2c_master_model.sv
/*
  Behavioural two-wire bus master that faces the converter control block.
  Assumes a pull-up on the data line: sda is the resolved wire level.
*/
`timescale 1ns/100ps
module i2c_master_model
(
  // Bus lines.
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ******************************************************************
  // Bit level
  // ******************************************************************
  localparam int Q = 16;

  // The clock stands high outside frames and the data line is released.
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Data falls while the clock is high.
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask

  // Data rises while the clock is high, leaving the bus idle.
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask

  // Data changes only while the clock is low and is sampled in the high half.
  task automatic bit_io(input logic b, output logic r);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask

  // Eight bits MSB first, then the slave acknowledge is read back.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // The master acknowledges all but the last byte it wants.
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule // i2c_master_model

// File: verification/tb.sv
/*
  Self-checking bench for the converter control block.
  Assumes the block's own assertions and a pulled-up data line.
*/
`timescale 1ns/100ps
module tb;
  import adc_ctrl_pkg::*;
  // ******************************************************************
  // Bench state
  // ******************************************************************
  localparam int         CONV = 4;
  localparam logic [6:0] ADDR = SLAVE_ADDR_DEFAULT;
  logic              clock    = 1'b0;
  logic              rst_b    = 1'b1;
  logic              pin_b    = 1'b1;
  logic [CODE_W-1:0] adc_code = 12'h000;
  wire               scl;
  wire               m_low;
  wire               sda;
  logic              sda_out;
  logic              sda_oe;
  logic              adc_hold;
  logic              adc_power_on;
  logic [CH_W-1:0]   adc_channel;
  int                mismatches  = 0;
  int                checks_done = 0;
  int                holds       = 0;

  // Clock, wired-AND data line, core result and hold counter.
  always #5 clock = ~clock;
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  always @(posedge clock) adc_code <= #1 {adc_channel, 9'h0A5};
  always @(posedge adc_hold) holds++;

  i2c_master_model mst (.scl(scl), .sda_low(m_low), .sda(sda));

  adc_conversion_mode_control #(.SLAVE_ADDR(ADDR), .CONV_CYCLES(CONV)) uut
  (
    .clock(clock), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .conversion_start_pin_b(pin_b), .adc_code(adc_code),
    .adc_hold(adc_hold), .adc_power_on(adc_power_on), .adc_channel(adc_channel)
  );

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] res(input logic [2:0] ch);
    return {ch, 1'b0, ch, 9'h0A5};
  endfunction

  // Pointer byte, then none, one or two data bytes.
  task automatic wreg(input logic [7:0] p, input logic [15:0] v, input int n);
    logic a;
    mst.start();
    mst.wr_byte({ADDR, 1'b0}, a);
    chk("write ack", 16'h0001, {15'h0000, a});
    mst.wr_byte(p, a);
    if (n == 2) mst.wr_byte(v[15:8], a);
    if (n > 0) mst.wr_byte(v[7:0], a);
    mst.stop();
  endtask

  task automatic rd_start();
    logic a;
    mst.start();
    mst.wr_byte({ADDR, 1'b1}, a);
    chk("read ack", 16'h0001, {15'h0000, a});
  endtask

  task automatic rd_lot(input logic last, output logic [15:0] w);
    mst.rd_byte(1'b0, w[15:8]);
    mst.rd_byte(last, w[7:0]);
    // The data line is updated on the fall that ends the byte, so look just after it.
    #1;
    if (last) chk("released", 16'h0000, {15'h0000, sda_oe});
  endtask

  // Start pin pulse, only while the bus is idle; hold length is counted.
  task automatic conv_pulse();
    int n;
    n = 0;
    @(posedge clock);
    #1 pin_b = 1'b0;
    // The window opens at the fall so that no hold cycle escapes the count.
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clock);
      #1 if (i == 3) pin_b = 1'b1;
      if (adc_hold === 1'b1) n++;
    end
    chk("hold cycles", CONV[15:0], n[15:0]);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    chk("reset hold", 16'h0000, {15'h0000, adc_hold});
    chk("reset channel", 16'h0000, {13'h0000, adc_channel});
    chk("reset power", 16'h0001, {15'h0000, adc_power_on});
    chk("reset oe", 16'h0000, {15'h0000, sda_oe});
    chk("reset drive level", 16'h0000, {15'h0000, sda_out});
    $display("test reset done");
  endtask

  // Results are read only after each conversion has ended.
  task automatic t_sample();
    logic [15:0] w;
    logic [2:0]  seq [3] = '{3'h1, 3'h2, 3'h1};
    int          h;
    h = holds;
    conv_pulse();
    rd_start();
    rd_lot(1'b1, w);
    mst.stop();
    chk("sample ch0", res(3'h0), w);
    wreg(PTR_CHAN, 16'h0006, 1);
    wreg(PTR_RESULT, 16'h0000, 0);
    foreach (seq[i])
    begin
      conv_pulse();
      rd_start();
      rd_lot(1'b1, w);
      mst.stop();
      chk("sample seq", res(seq[i]), w);
    end
    chk("hold count", 16'h0004, 16'(holds - h));
    $display("test sample done");
  endtask

  task automatic t_pointer();
    logic [15:0] w;
    logic        a;
    wreg(PTR_CHAN, 16'h0000, 0);
    rd_start();
    rd_lot(1'b0, w);
    chk("chan lot1", 16'h0006, w);
    rd_lot(1'b1, w);
    mst.stop();
    chk("chan lot2", 16'h0006, w);
    rd_start();
    rd_lot(1'b1, w);
    mst.stop();
    chk("chan again", 16'h0006, w);
    mst.start();
    mst.wr_byte({7'h10, 1'b1}, a);
    mst.stop();
    chk("foreign ack", 16'h0000, {15'h0000, a});
    $display("test pointer done");
  endtask

  task automatic t_command();
    logic [15:0] w;
    wreg(PTR_CFG, 16'h0300, 2);
    wreg(PTR_CHAN, 16'h0007, 1);
    wreg(PTR_RESULT, 16'h0000, 0);
    rd_start();
    for (int i = 0; i < 4; i++)
    begin
      rd_lot(i == 3, w);
      chk("cmd seq", res(3'(i % 3)), w);
    end
    mst.stop();
    repeat (20) @(posedge clock);
    #1 chk("powered down", 16'h0000, {15'h0000, adc_power_on});
    wreg(PTR_CFG, 16'h0000, 0);
    rd_start();
    rd_lot(1'b1, w);
    mst.stop();
    chk("cfg kept", 16'h0300, w);
    wreg(PTR_RESULT, 16'h0000, 0);
    rd_start();
    rd_lot(1'b1, w);
    mst.stop();
    chk("resume", res(3'h1), w);
    wreg(PTR_CHAN, 16'h0007, 1);
    wreg(PTR_RESULT, 16'h0000, 0);
    rd_start();
    rd_lot(1'b1, w);
    mst.stop();
    chk("restart", res(3'h0), w);
    $display("test command done");
  endtask

  // Both mode bits set, then both clear, each give sample mode.
  task automatic t_modes();
    int h;
    wreg(PTR_CFG, 16'h1100, 2);
    h = holds;
    conv_pulse();
    chk("both set", 16'h0001, 16'(holds - h));
    wreg(PTR_CFG, 16'h0000, 2);
    conv_pulse();
    chk("both clear", 16'h0002, 16'(holds - h));
    $display("test modes done");
  endtask

  // ******************************************************************
  // Run control
  // ******************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 46 us.
  initial
  begin
    #400_000;
    mismatches++;
    close_out();
  end

  // Main sequence: reset for 20 cycles, then the scenarios.
  initial
  begin
    #2 rst_b = 1'b0; // A real falling edge, so the link-side flops see the reset.
    repeat (10) @(posedge clock);
    #1 t_reset();
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    t_sample();
    t_pointer();
    t_command();
    t_modes();
    close_out();
  end
endmodule // tb
